// file: verilog/ptqm_consts.svh
// Register indices, field positions, reset values for the priority mapper.
// Assumes it is included by bare name after the package is compiled.
`ifndef PTQM_CONSTS_SVH
`define PTQM_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define PTQM_IDX_TAG_MAP     8'h81
`define PTQM_IDX_SPLIT       8'h82
`define PTQM_IDX_STATUS      8'hF0
`define PTQM_ADDR_TAG_MAP    {`PTQM_IDX_TAG_MAP, 2'h0}
`define PTQM_ADDR_SPLIT      {`PTQM_IDX_SPLIT, 2'h0}
`define PTQM_ADDR_STATUS     {`PTQM_IDX_STATUS, 2'h0}
`define PTQM_ADDR_W          10

// Tag map field positions: tag four at the bottom, two bits per tag.
`define PTQM_TAG_FIELD_W     2
`define PTQM_TAG_FIRST       3'h4
`define PTQM_TAG_COUNT       4

// Split field and fixed read-back of the reserved bits around it.
`define PTQM_SPLIT_LSB       6
`define PTQM_SPLIT_MSB       7
`define PTQM_SPLIT_RSVD      8'h04

// Status register field positions.
`define PTQM_STAT_PRIO_LSB   0
`define PTQM_STAT_PRIO_MSB   1
`define PTQM_STAT_QHIGH      2
`define PTQM_STAT_TWOQ       3
`define PTQM_STAT_SEEN       4

// Reset values.
`define PTQM_TAG_MAP_RESET   8'hFA
`define PTQM_SPLIT_RESET     2'h2
`define PTQM_PRIO_RESET      2'h0

`endif

// file: verilog/ptqm_pkg.sv
// Types shared by the priority-to-queue mapper and its queue fold.
// Assumes nothing beyond a SystemVerilog compiler.
package ptqm_pkg;

	// One frame offered for classification.
	typedef struct packed {
		logic       valid;
		logic [2:0] tag;
		logic [1:0] low_tag_prio;
		logic [1:0] ds_prio;
		logic       use_ds;
	} ptqm_frame_type;

	// Classification answer for one frame.
	typedef struct packed {
		logic       valid;
		logic [1:0] prio;
		logic       queue_high;
	} ptqm_class_type;

	typedef enum logic {
		BUS_IDLE,
		BUS_ANSWER
	} ptqm_bus_state_type;

endpackage

// file: verilog/ptqm_queue_fold.sv
// Folds a 2-bit priority result into a low or high queue.
// Assumes the split field comes straight from the control register.
`timescale 1ns/10ps
module ptqm_queue_fold (
	input  logic       two_queue,
	input  logic [1:0] prio,
	input  logic [1:0] split,
	output logic       queue_high
);
	import ptqm_pkg::*;

	always_comb begin
		if (!two_queue) begin
			// In four-queue operation the result goes out unfolded.
			queue_high = 1'b0;
		end else begin
			case (prio)
				2'h0: queue_high = 1'b0;
				2'h1: queue_high = split[0];
				2'h2: queue_high = split[1];
				2'h3: queue_high = 1'b1;
				default: queue_high = 1'b0;
			endcase
		end
	end

endmodule

// file: verilog/ptqm_top.sv
// Frame priority classifier with 802.1p tag map and two-queue fold.
// Assumes an Avalon-MM master on the core clock and a frame source that
// presents one request per cycle with the lower-tag map already applied.
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "ptqm_consts.svh"

module ptqm_top (
	input  logic                    CLK,
	input  logic                    RESET,
	input  logic [`PTQM_ADDR_W-1:0] AVS_ADDRESS,
	input  logic                    AVS_READ,
	input  logic                    AVS_WRITE,
	input  logic [31:0]             AVS_WRITEDATA,
	input  logic [3:0]              AVS_BYTEENABLE,
	output logic [31:0]             AVS_READDATA,
	output logic                    AVS_WAITREQUEST,
	input  logic                    TWO_QUEUE,
	input  ptqm_pkg::ptqm_frame_type FRAME_IN,
	output ptqm_pkg::ptqm_class_type CLASS_OUT
);
	import ptqm_pkg::*;

	localparam int NTAG = `PTQM_TAG_COUNT;
	localparam int FW   = `PTQM_TAG_FIELD_W;

	ptqm_bus_state_type bus_state;
	ptqm_bus_state_type next_bus_state;
	logic [7:0]         tag_priority_map_low_tags;
	logic [1:0]         two_queue_split;
	logic [31:0]        read_word;
	logic               commit_write;
	logic               hit_tag_map;
	logic               hit_split;
	logic               hit_status;
	logic [1:0]         tag_field [NTAG];
	logic [1:0]         dot1p_prio;
	logic [1:0]         result_prio;
	logic               fold_high;
	logic [2:0]         tag_offset;
	logic [1:0]         last_prio;
	logic               last_high;
	logic               last_seen;

	// ------------------------------------------------------------------
	// Bus slave: every access waits exactly one cycle, so read data can
	// come from a flop without a combinational path from the address.
	// ------------------------------------------------------------------
	assign hit_tag_map = (AVS_ADDRESS == `PTQM_ADDR_TAG_MAP);
	assign hit_split   = (AVS_ADDRESS == `PTQM_ADDR_SPLIT);
	assign hit_status  = (AVS_ADDRESS == `PTQM_ADDR_STATUS);

	always_comb begin
		next_bus_state = bus_state;
		case (bus_state)
			BUS_IDLE: begin
				if (AVS_READ || AVS_WRITE) begin
					next_bus_state = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				next_bus_state = BUS_IDLE;
			end
			default: begin
				next_bus_state = BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			bus_state <= BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// The request is released by the master right after the answering edge,
	// so waitrequest only drops during the answer cycle.
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) &&
		(bus_state != BUS_ANSWER);

	assign commit_write = AVS_WRITE && (bus_state == BUS_ANSWER) &&
		AVS_BYTEENABLE[0];

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		read_word = 32'h0000_0000;
		if (hit_tag_map) begin
			read_word[7:0] = tag_priority_map_low_tags;
		end else if (hit_split) begin
			read_word[7:0] = `PTQM_SPLIT_RSVD;
			read_word[`PTQM_SPLIT_MSB:`PTQM_SPLIT_LSB] = two_queue_split;
		end else if (hit_status) begin
			read_word[`PTQM_STAT_PRIO_MSB:`PTQM_STAT_PRIO_LSB] = last_prio;
			read_word[`PTQM_STAT_QHIGH] = last_high;
			read_word[`PTQM_STAT_TWOQ]  = TWO_QUEUE;
			read_word[`PTQM_STAT_SEEN]  = last_seen;
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (AVS_READ && (bus_state == BUS_IDLE)) begin
			AVS_READDATA <= read_word;
		end
	end

	// ------------------------------------------------------------------
	// Control registers.
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tag_priority_map_low_tags <= `PTQM_TAG_MAP_RESET;
		end else if (commit_write && hit_tag_map) begin
			tag_priority_map_low_tags <= AVS_WRITEDATA[7:0];
		end
	end

	// The unsupported split code is stored as written; the fold then
	// applies the bits literally. Software is expected never to use it.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			two_queue_split <= `PTQM_SPLIT_RESET;
		end else if (commit_write && hit_split) begin
			two_queue_split <=
				AVS_WRITEDATA[`PTQM_SPLIT_MSB:`PTQM_SPLIT_LSB];
		end
	end

	// ------------------------------------------------------------------
	// 802.1p map: one field per tag from four upward.
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NTAG; gi++) begin : g_tag
			assign tag_field[gi] =
				tag_priority_map_low_tags[gi*FW +: FW];
		end
	endgenerate

	assign tag_offset = FRAME_IN.tag - `PTQM_TAG_FIRST;

	always_comb begin
		if (FRAME_IN.tag >= `PTQM_TAG_FIRST) begin
			dot1p_prio = tag_field[tag_offset[1:0]];
		end else begin
			// Lower tags come already mapped from the neighbouring map.
			dot1p_prio = FRAME_IN.low_tag_prio;
		end
	end

	assign result_prio = FRAME_IN.use_ds ? FRAME_IN.ds_prio : dot1p_prio;

	ptqm_queue_fold u_fold (
		.two_queue  (TWO_QUEUE),
		.prio       (result_prio),
		.split      (two_queue_split),
		.queue_high (fold_high)
	);

	// ------------------------------------------------------------------
	// Registered answer, one cycle after the frame is offered.
	// ------------------------------------------------------------------
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			CLASS_OUT <= '0;
		end else begin
			CLASS_OUT.valid      <= FRAME_IN.valid;
			CLASS_OUT.prio       <= result_prio;
			CLASS_OUT.queue_high <= fold_high;
		end
	end

	// Status keeps the last classified frame for software inspection.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			last_prio <= `PTQM_PRIO_RESET;
			last_high <= 1'b0;
			last_seen <= 1'b0;
		end else if (FRAME_IN.valid) begin
			last_prio <= result_prio;
			last_high <= fold_high;
			last_seen <= 1'b1;
		end
	end

endmodule

// file: test/ptqm_sva.sv
// Port checker for the priority-to-queue mapper.
// Assumes binding to ptqm_top; it shadows the registers from bus writes.
`timescale 1ns/10ps
`include "ptqm_consts.svh"
module ptqm_sva (
	input logic                     CLK,
	input logic                     RESET,
	input logic [`PTQM_ADDR_W-1:0]  AVS_ADDRESS,
	input logic                     AVS_READ,
	input logic                     AVS_WRITE,
	input logic [31:0]              AVS_WRITEDATA,
	input logic [3:0]               AVS_BYTEENABLE,
	input logic [31:0]              AVS_READDATA,
	input logic                     AVS_WAITREQUEST,
	input logic                     TWO_QUEUE,
	input ptqm_pkg::ptqm_frame_type FRAME_IN,
	input ptqm_pkg::ptqm_class_type CLASS_OUT
);
	import ptqm_pkg::*;
	logic [7:0] tm;
	logic [1:0] sp;
	logic [1:0] sp_q;
	logic       wr;
	assign wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
	// The fold result lags one edge, so the split it used is kept as sp_q.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tm <= `PTQM_TAG_MAP_RESET;
			sp <= `PTQM_SPLIT_RESET;
			sp_q <= `PTQM_SPLIT_RESET;
		end else begin
			sp_q <= sp;
			if (wr && AVS_ADDRESS == `PTQM_ADDR_TAG_MAP) begin
				tm <= AVS_WRITEDATA[7:0];
			end
			if (wr && AVS_ADDRESS == `PTQM_ADDR_SPLIT) begin
				sp <= AVS_WRITEDATA[7:6];
			end
		end
	end
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (RESET);
	a_tag_four_prio: assert property (
		FRAME_IN.tag == 3'h4 && !FRAME_IN.use_ds
		|=> {6'h00, CLASS_OUT.prio} == ($past(tm) & 8'h03)) else $error("tag four");
	a_tag_five_prio: assert property (
		FRAME_IN.tag == 3'h5 && !FRAME_IN.use_ds
		|=> {4'h0, CLASS_OUT.prio, 2'h0} == ($past(tm) & 8'h0C)) else $error("tag five");
	a_single_queue: assert property (
		!TWO_QUEUE |=> !CLASS_OUT.queue_high) else $error("single queue");
	a_end_results: assert property (
		$past(TWO_QUEUE) && CLASS_OUT.valid && CLASS_OUT.prio inside {2'h0, 2'h3}
		|-> CLASS_OUT.queue_high == CLASS_OUT.prio[0]) else $error("end results");
	a_middle_split: assert property (
		$past(TWO_QUEUE) && CLASS_OUT.valid && CLASS_OUT.prio inside {2'h1, 2'h2}
		|-> CLASS_OUT.queue_high == sp_q[CLASS_OUT.prio[1]]) else $error("middle");
	a_split_all_high: assert property (
		$past(TWO_QUEUE) && CLASS_OUT.valid && sp_q == 2'h3
		|-> CLASS_OUT.queue_high == (CLASS_OUT.prio != 2'h0)) else $error("split 11");
	a_split_all_low: assert property (
		$past(TWO_QUEUE) && CLASS_OUT.valid && sp_q == 2'h0
		|-> CLASS_OUT.queue_high == (CLASS_OUT.prio == 2'h3)) else $error("split 00");
	a_split_readback: assert property (
		AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `PTQM_ADDR_SPLIT
		|-> AVS_READDATA[7:0] == ({sp, 6'h00} | `PTQM_SPLIT_RSVD)) else $error("split");
endmodule
bind ptqm_top ptqm_sva u_sva (.CLK(CLK), .RESET(RESET),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.TWO_QUEUE(TWO_QUEUE), .FRAME_IN(FRAME_IN), .CLASS_OUT(CLASS_OUT));

// file: test/ptqm_tb_top.sv
// Testbench for the priority mapper: register and classify scenarios.
// Assumes ptqm_top with its checker bound; one 50 MHz clock.
`timescale 1ns/10ps
`include "ptqm_consts.svh"
module ptqm_tb_top;
	import ptqm_pkg::*;
	logic                    clk = 1'b0;
	logic                    reset = 1'b1;
	logic [`PTQM_ADDR_W-1:0] addr = 10'h000;
	logic                    rd = 1'b0;
	logic                    wr = 1'b0;
	logic [31:0]             wdata = 32'h0;
	logic [31:0]             rdata;
	logic                    waitreq;
	logic                    two_q = 1'b0;
	logic [3:0]              be = 4'hF;
	ptqm_frame_type          frame = 9'h000;
	ptqm_class_type          cls;
	int                      error_cnt = 0;
	int                      samples_checked = 0;
	always #10 clk = ~clk;
	ptqm_top dut (.CLK(clk), .RESET(reset), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
		.TWO_QUEUE(two_q), .FRAME_IN(frame), .CLASS_OUT(cls));
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// The request is held until the edge that samples waitrequest low.
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= {24'h000000, d};
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 50) begin
			error_cnt++;
			$display("wrong value at %0t: bus timeout", $time);
			tally_and_finish();
		end
	endtask
	task automatic rchk(input logic [9:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, {24'h000000, e});
	endtask
	task automatic frm(input logic [2:0] tag, input logic [1:0] ds,
		input logic ud, input logic tq, input logic [1:0] ep, input logic eq);
		@(posedge clk);
		frame <= {1'b1, tag, 2'h1, ds, ud};
		two_q <= tq;
		@(posedge clk);
		#1;
		chk({28'h0, cls}, {28'h0, 1'b1, ep, eq});
	endtask
	task automatic t_reset_values();
		rchk(`PTQM_ADDR_TAG_MAP, `PTQM_TAG_MAP_RESET);
		rchk(`PTQM_ADDR_SPLIT, 8'h84);
		rchk(10'h004, 8'h00);
		frm(3'h4, 2'h0, 1'b0, 1'b1, 2'h2, 1'b1);
		frm(3'h0, 2'h1, 1'b1, 1'b1, 2'h1, 1'b0);
		// Status holds the last frame: prio one, low, two-queue, seen.
		rchk(`PTQM_ADDR_STATUS, 8'h19);
	endtask
	task automatic t_tag_map();
		logic [31:0] q;
		// A write without the low byte lane must leave the map untouched.
		be <= 4'h0;
		bus(1'b1, `PTQM_ADDR_TAG_MAP, 8'h00, q);
		be <= 4'hF;
		rchk(`PTQM_ADDR_TAG_MAP, `PTQM_TAG_MAP_RESET);
		bus(1'b1, `PTQM_ADDR_TAG_MAP, 8'hE4, q);
		rchk(`PTQM_ADDR_TAG_MAP, 8'hE4);
		frm(3'h4, 2'h3, 1'b0, 1'b0, 2'h0, 1'b0);
		frm(3'h5, 2'h3, 1'b0, 1'b0, 2'h1, 1'b0);
	endtask
	task automatic t_fold();
		// Only supported split codes are programmed.
		logic [1:0]  s [3] = '{2'h0, 2'h3, 2'h2};
		logic [1:0]  p;
		logic [31:0] q;
		logic        e;
		foreach (s[i]) begin
			bus(1'b1, `PTQM_ADDR_SPLIT, {s[i], 6'h00}, q);
			rchk(`PTQM_ADDR_SPLIT, {s[i], 6'h04});
			for (int k = 0; k < 4; k++) begin
				p = 2'(k);
				e = (p == 2'h3) || (p != 2'h0 && s[i][p[1]]);
				frm(3'h0, p, 1'b1, 1'b1, p, e);
				frm(3'h0, p, 1'b1, 1'b0, p, 1'b0);
			end
		end
	endtask
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		t_reset_values();
		t_tag_map();
		t_fold();
		tally_and_finish();
	end
endmodule
